// File: verilog/i2csm_status.sv
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module i2csm_status
  import i2csm_pkg::*;
(
  input  wire logic        hclk,      // bus clock, 40 mhz
  input  wire logic        hresetn,   // async reset, low active
  input  wire logic        ce,        // clock enable, low freezes all
  input  wire logic        hsel,      // slave select
  input  wire logic [7:0]  haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [2:0]  hsize,     // word only
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready in
  output logic             hreadyout, // always ready
  output logic             hresp,     // always okay
  output logic [31:0]      hrdata,    // read data
  input  wire logic        scl_in,    // serial clock pin level
  input  wire logic        sda_in,    // serial data pin level
  output logic             sda_out,   // data pin drive value
  output logic             sda_oe_n,  // data pin enable, low drives
  input  wire logic        so_latch,  // shift-output latch bit
  input  wire logic        start_gen, // pulse: master made a start
  input  wire logic        arb_lost,  // pulse: arbitration lost
  output logic             irq        // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser state, bit 1 data, bit 0 clock
  logic [1:0] sync1_reg, sync1_next; // first stage, read by stage two only
  logic [1:0] sync2_reg, sync2_next; // second stage
  logic [1:0] sync3_reg, sync3_next; // third stage
  logic [1:0] lvl_reg,   lvl_next;   // agreed levels

  // next values for the synchroniser
  always_comb
  begin
    sync1_next = {sda_in, scl_in};
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    // a change only counts once stages two and three agree
    lvl_next = ((sync2_reg ~^ sync3_reg) & sync3_reg)
             | ((sync2_reg ^ sync3_reg) & lvl_reg);
  end

  // synchroniser registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
      sync3_reg <= 2'h3;
      lvl_reg   <= 2'h3;
    end
    else if (ce)
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      lvl_reg   <= lvl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line events derived from agreed levels
  logic scl_rise;  // serial clock rising
  logic scl_fall;  // serial clock falling
  logic start_det; // data falls while clock high
  logic stop_det;  // data rises while clock high
  logic sda_now;   // data level at this edge

  always_comb
  begin
    scl_rise  = lvl_next[0] & ~lvl_reg[0];
    scl_fall  = ~lvl_next[0] & lvl_reg[0];
    start_det = lvl_reg[0] & lvl_next[0] & lvl_reg[1] & ~lvl_next[1];
    stop_det  = lvl_reg[0] & lvl_next[0] & ~lvl_reg[1] & lvl_next[1];
    sda_now   = lvl_next[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave state
  logic        dph_reg,   dph_next;   // write data phase pending
  logic [7:0]  dadr_reg,  dadr_next;  // address of pending write
  logic [31:0] rdata_reg, rdata_next; // read data
  logic [7:0]  ctrl_reg,  ctrl_next;  // control, enable bit only kept
  logic [6:0]  sva_reg,   sva_next;   // local_slave_addr
  logic [3:0]  mask_reg,  mask_next;  // irq mask
  logic [3:0]  ist_reg,   ist_next;   // sticky irq status
  logic        addr_ph;               // valid address phase
  logic        rd_status;             // status read, clears arb flag
  logic        rd_irq;                // irq status read
  logic        wr_ctrl;               // control write in data phase
  logic        comm_rel;              // comm_release_bit written as one
  logic        wait_rel;              // wait_release_bit written as one
  logic        en_fall;               // iface enable goes one to zero
  logic [3:0]  ev;                    // events of this cycle

  i2csm_flags_type flags_reg, flags_next; // status flags

  // bus decode and register next values
  always_comb
  begin
    addr_ph    = hsel & hready & (htrans == HTRANS_NSEQ);
    dph_next   = addr_ph & hwrite;
    dadr_next  = addr_ph ? haddr : dadr_reg;
    rd_status  = addr_ph & ~hwrite & (haddr == OFS_STATUS);
    rd_irq     = addr_ph & ~hwrite & (haddr == OFS_IRQ_ST);
    wr_ctrl    = dph_reg & (dadr_reg == OFS_CONTROL);
    comm_rel   = wr_ctrl & hwdata[CTL_COMM_REL];
    wait_rel   = wr_ctrl & hwdata[CTL_WAIT_REL];
    en_fall    = wr_ctrl & ~hwdata[CTL_IF_EN] & ctrl_reg[CTL_IF_EN];
    ctrl_next  = ctrl_reg;
    sva_next   = sva_reg;
    mask_next  = mask_reg;
    rdata_next = rdata_reg;
    // only the enable is stored; release bits are strobes, read zero
    if (wr_ctrl)
      ctrl_next = {hwdata[CTL_IF_EN], 7'h00};
    if (dph_reg && dadr_reg == OFS_SLV_ADDR)
      sva_next = hwdata[6:0];
    if (dph_reg && dadr_reg == OFS_IRQ_MASK)
      mask_next = hwdata[3:0];
    // read data captured at the address phase, zero wait states
    if (addr_ph && !hwrite)
    begin
      if (haddr == OFS_CONTROL)
        rdata_next = {24'h000000, ctrl_reg};
      else if (haddr == OFS_SLV_ADDR)
        rdata_next = {25'h0000000, sva_reg};
      else if (haddr == OFS_STATUS)
        rdata_next = {24'h000000, flags_reg.master, flags_reg.arb, 1'b0,
                      flags_reg.match, flags_reg.dir, flags_reg.ack, 2'h0};
      else if (haddr == OFS_IRQ_ST)
        rdata_next = {28'h0000000, ist_reg};
      else if (haddr == OFS_IRQ_MASK)
        rdata_next = {28'h0000000, mask_reg};
      else
        rdata_next = 32'h00000000; // unmapped reads zero
    end
    // event set wins over the read that clears
    ist_next = (rd_irq ? 4'h0 : ist_reg) | ev;
  end

  // bus slave registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_reg   <= 1'b0;
      dadr_reg  <= 8'h00;
      rdata_reg <= 32'h00000000;
      ctrl_reg  <= RST_CONTROL;
      sva_reg   <= RST_SLV_ADDR;
      mask_reg  <= RST_IRQ;
      ist_reg   <= RST_IRQ;
    end
    else if (ce)
    begin
      dph_reg   <= dph_next;
      dadr_reg  <= dadr_next;
      rdata_reg <= rdata_next;
      ctrl_reg  <= ctrl_next;
      sva_reg   <= sva_next;
      mask_reg  <= mask_next;
      ist_reg   <= ist_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial protocol state
  logic [3:0] cnt_reg,   cnt_next;   // clocks seen in this byte
  logic       first_reg, first_next; // inside the address byte
  logic [6:0] shr_reg,   shr_next;   // bits shifted in so far
  logic       drv_reg,   drv_next;   // output phase has begun
  logic       oe_n_reg,  oe_n_next;  // registered pin enable
  logic       gclr;                  // comm release write or disable
  logic [7:0] rx_byte;               // byte completed at eighth rise
  logic       eighth;                // rising edge of eighth clock
  logic       ninth;                 // rising edge of ninth clock

  // flag and counter next values; clears first, sets last so sets win, except that arb loss clears master last
  always_comb
  begin
    gclr       = comm_rel | en_fall;
    cnt_next   = cnt_reg;
    first_next = first_reg;
    shr_next   = shr_reg;
    drv_next   = drv_reg;
    flags_next = flags_reg;
    rx_byte    = {shr_reg, sda_now};
    eighth     = scl_rise & (cnt_reg == BIT_ADDR_END);
    ninth      = scl_rise & (cnt_reg == 4'h8);
    ev         = 4'h0;
    // bit counting on agreed clock edges
    if (scl_rise && cnt_reg != BIT_ACK)
    begin
      cnt_next = cnt_reg + 4'h1;
      shr_next = rx_byte[6:0];
    end
    if (scl_fall && cnt_reg == BIT_ACK)
    begin
      cnt_next   = 4'h0;
      first_next = 1'b0;
      // output phase opens at falling edge of the first byte's ninth
      if (first_reg)
        drv_next = 1'b1;
    end
    if (start_det)
    begin
      cnt_next   = 4'h0;
      first_next = 1'b1;
      drv_next   = 1'b0;
    end
    // ---- clears ----
    if (start_det || stop_det || gclr)
      flags_next.match = 1'b0;
    if (stop_det || gclr)
    begin
      flags_next.dir = 1'b0;
      flags_next.ack = 1'b0;
      drv_next       = 1'b0;
    end
    // slave not taking part drops transmit status at a start
    if (start_det && !flags_reg.master)
      flags_next.dir = 1'b0;
    if (scl_rise && cnt_reg == 4'h0)
      flags_next.ack = 1'b0;
    if (eighth && first_reg && flags_reg.master && sda_now)
      flags_next.dir = 1'b0;
    if (wait_rel && flags_reg.dir && cnt_reg == BIT_ACK)
    begin
      flags_next.dir = 1'b0;
      drv_next       = 1'b0;
    end
    if (arb_lost && !flags_reg.arb)
      flags_next.dir = 1'b0;
    if (rd_status || en_fall)
      flags_next.arb = 1'b0;
    if (comm_rel || en_fall)
      flags_next.master = 1'b0;
    // ---- sets ----
    if (start_gen)
    begin
      flags_next.master = 1'b1;
      flags_next.dir    = 1'b1;
    end
    if (eighth && first_reg)
    begin
      if (rx_byte[7:1] == sva_reg)
      begin
        flags_next.match = 1'b1;
        ev[EV_MATCH]     = 1'b1;
      end
      if (!flags_reg.master && rx_byte[0])
        flags_next.dir = 1'b1;
    end
    if (ninth && !sda_now)
    begin
      flags_next.ack = 1'b1;
      ev[EV_ACK]     = 1'b1;
    end
    if (arb_lost)
    begin
      flags_next.arb    = 1'b1;
      flags_next.master = 1'b0;
      ev[EV_ARB]        = 1'b1;
    end
    ev[EV_STOP] = stop_det;
    // open drain: only a zero is driven, only in transmit status
    oe_n_next = ~(flags_next.dir & drv_next & ~so_latch);
  end

  // protocol registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg   <= 4'h0;
      first_reg <= 1'b0;
      shr_reg   <= 7'h00;
      drv_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
      flags_reg <= RST_FLAGS;
    end
    else if (ce)
    begin
      cnt_reg   <= cnt_next;
      first_reg <= first_next;
      shr_reg   <= shr_next;
      drv_reg   <= drv_next;
      oe_n_reg  <= oe_n_next;
      flags_reg <= flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign sda_out   = 1'b0;        // pin pulled low only when enabled
  assign sda_oe_n  = oe_n_reg;
  assign irq       = |(ist_reg & mask_reg);

endmodule : i2csm_status
`default_nettype wire

// File: verilog/i2csm_pkg.sv
package i2csm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] OFS_CONTROL  = 8'h00; // control, rw
  localparam logic [7:0] OFS_SLV_ADDR = 8'h04; // local slave address, rw
  localparam logic [7:0] OFS_STATUS   = 8'h08; // flag status, ro
  localparam logic [7:0] OFS_IRQ_ST   = 8'h0C; // sticky events, read clears
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10; // event enables, rw

  ////////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int CTL_WAIT_REL = 5; // wait_release_bit, self clearing
  localparam int CTL_COMM_REL = 6; // comm_release_bit, self clearing
  localparam int CTL_IF_EN    = 7; // iface_enable_bit

  // status field positions
  localparam int ST_MASTER = 7; // master_state_flag
  localparam int ST_ARB    = 6; // arb_loss_flag
  localparam int ST_MATCH  = 4; // addr_match_flag
  localparam int ST_DIR    = 3; // xmit_dir_flag
  localparam int ST_ACK    = 2; // ack_seen_flag

  // event bit positions of irq status and mask
  localparam int EV_MATCH = 0; // address matched
  localparam int EV_ACK   = 1; // ack seen
  localparam int EV_ARB   = 2; // arbitration lost
  localparam int EV_STOP  = 3; // stop detected
  localparam int EV_W     = 4; // number of events

  ////////////////////////////////////////////////////////////////////////////
  // reset values and bit counts
  localparam logic [7:0]  RST_CONTROL  = 8'h00;
  localparam logic [6:0]  RST_SLV_ADDR = 7'h00;
  localparam logic [3:0]  RST_IRQ      = 4'h0;
  localparam logic [3:0]  BIT_ADDR_END = 4'h7; // count before eighth clock
  localparam logic [3:0]  BIT_ACK      = 4'h9; // ninth clock
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

  // status flags travel together
  typedef struct packed {
    logic master; // master_state_flag
    logic arb;    // arb_loss_flag
    logic match;  // addr_match_flag
    logic dir;    // xmit_dir_flag
    logic ack;    // ack_seen_flag
  } i2csm_flags_type;

  localparam i2csm_flags_type RST_FLAGS = '0;

endpackage : i2csm_pkg

// File: dv/i2csm_remote.sv
`timescale 1ns/10ps
`default_nettype none
module i2csm_remote
(
  input  wire logic hclk,           // bench clock
  output logic      scl_drv = 1'b1, // serial clock, still high when idle
  output logic      sda_drv = 1'b1  // data drive, 1 releases to pull-up
);
  ////////////////////////////////////////
  // idle wait counted in bench clocks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_clk

  // data moves only while the clock is low, 200 ns per bit
  task automatic send_bit(input logic b);
    sda_drv <= b;
    wait_clk(2);
    scl_drv <= 1'b1;
    wait_clk(4);
    scl_drv <= 1'b0;
    wait_clk(2);
  endtask : send_bit

  // eight bits msb first, then the ack slot
  task automatic send_byte(input logic [7:0] d, input logic ak);
    for (int i = 7; i >= 0; i--)
      send_bit(d[i]);
    send_bit(ak);
  endtask : send_byte

  // only from an idle bus: data falls while clock high
  task automatic start_cond();
    sda_drv <= 1'b0;
    wait_clk(4);
    scl_drv <= 1'b0;
    wait_clk(2);
  endtask : start_cond

  // data rises while clock high; leaves the bus idle
  task automatic stop_cond();
    sda_drv <= 1'b0;
    wait_clk(2);
    scl_drv <= 1'b1;
    wait_clk(4);
    sda_drv <= 1'b1;
    wait_clk(4);
  endtask : stop_cond
endmodule : i2csm_remote
`default_nettype wire

// File: dv/i2csm_properties.sv
`timescale 1ns/10ps
`default_nettype none
module i2csm_properties
  import i2csm_pkg::*;
(
  input wire logic        hclk,      // bus clock
  input wire logic        hresetn,   // reset, low active
  input wire logic        ce,        // clock enable
  input wire logic        hsel,      // select
  input wire logic [7:0]  haddr,     // address
  input wire logic [1:0]  htrans,    // transfer type
  input wire logic        hwrite,    // write
  input wire logic        hready,    // bus ready
  input wire logic        hreadyout, // slave ready
  input wire logic        hresp,     // response
  input wire logic [31:0] hrdata,    // read data
  input wire logic        scl_in,    // clock pin
  input wire logic        sda_in,    // data pin
  input wire logic        sda_oe_n,  // low drives
  input wire logic        so_latch,  // bit to send
  input wire logic        arb_lost,  // loss pulse
  input wire logic        irq        // interrupt
);
  // read address phase accepted at this edge
  wire logic rd_req = hsel && hready && htrans == HTRANS_NSEQ && !hwrite && ce;
  logic [5:0] idle_reg, idle_next; // pins and still-cycle count

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////
  // count saturates: sync lag needs a few still cycles
  always_comb
  begin
    idle_next = {scl_in, sda_in, 4'h0};
    if (idle_next[5:4] == idle_reg[5:4])
      idle_next[3:0] = (idle_reg[3:0] == 4'hF) ? 4'hF : idle_reg[3:0] + 4'h1;
  end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      idle_reg <= 6'h30; // idle bus
    else
      idle_reg <= idle_next;

  ////////////////////////////////////////
  chk_reset_clean: assert property ($rose(hresetn) |->
      hrdata == 32'h0 && sda_oe_n && !irq)
    else $error("outputs not clean after reset");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  chk_rdata_hold: assert property (!rd_req |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (
      rd_req && haddr > 8'h13 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_strobe_read0: assert property (
      rd_req && haddr == OFS_CONTROL |=> hrdata[6:5] == 2'h0)
    else $error("release strobes read back set");
  chk_irq_read_clear: assert property (rd_req && haddr == OFS_IRQ_ST &&
      !arb_lost && idle_reg[3:0] == 4'hF |=> !irq)
    else $error("interrupt stayed after status read");
  chk_drive_latch: assert property (
      !sda_oe_n && $past(ce) |-> !$past(so_latch))
    else $error("data driven against the latch");
  chk_freeze_hold: assert property (
      !ce |=> $stable(hrdata) && $stable(sda_oe_n))
    else $error("outputs moved while frozen");

  cover property (rd_req && haddr == OFS_STATUS);
  cover property (!sda_oe_n);
  cover property (irq);
endmodule : i2csm_properties

bind i2csm_status i2csm_properties i_props (.hclk, .hresetn, .ce, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .scl_in,
  .sda_in, .sda_oe_n, .so_latch, .arb_lost, .irq);
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin samples_checked++; if ((gt) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module testbench
  import i2csm_pkg::*;
;
  logic        hclk, hresetn = 1'b0, ce = 1'b1;     // clock, reset, enable
  logic        hsel = 1'b0, hwrite = 1'b0;          // bus controls
  logic [7:0]  haddr = 8'h00;                       // byte address
  logic [1:0]  htrans = 2'h0;                       // transfer type
  logic [2:0]  hsize = 3'h0;                        // word in address phase
  logic [31:0] hwdata = 32'h0, hrdata;              // bus data
  logic        hreadyout, sda_out, sda_oe_n;        // dut outputs
  logic        irq, so_latch = 1'b1;                // interrupt, tx bit
  logic        start_gen = 1'b0, arb_lost = 1'b0;   // controller pulses
  wire         sda_in, scl_drv, sda_drv;            // link wires
  int          fail_count = 0, samples_checked = 0; // verdict counters
  logic [6:0]  loc, oth;                            // own, foreign address
  logic        rd_dp = 1'b0;                        // read data phase
  logic [39:0] note_q[$], note;                     // {address, expected}

  assign sda_in = sda_drv & (sda_oe_n | sda_out); // open drain, pulled up

  i2csm_status i_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
    .scl_in(scl_drv), .sda_in, .sda_out, .sda_oe_n, .so_latch, .start_gen,
    .arb_lost, .irq);
  i2csm_remote i_rem (.hclk, .scl_drv, .sda_drv);

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  ////////////////////////////////////////
  // one single transfer; a read notes what it should return
  task automatic ahb(input logic w, input logic [7:0] a, logic [31:0] d);
    if (!w)
      note_q.push_back({a, d});
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hsize  <= 3'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb

  // one-cycle pulse on a controller input
  task automatic pulse(input logic arb);
    start_gen <= !arb;
    arb_lost  <= arb;
    @(posedge hclk);
    start_gen <= 1'b0;
    arb_lost  <= 1'b0;
    @(posedge hclk);
  endtask : pulse

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // read data looked at mid data phase, clear of both edges
  always @(posedge hclk)
    rd_dp <= hsel && hreadyout && ce && htrans == HTRANS_NSEQ && !hwrite;
  always @(negedge hclk)
    if (rd_dp)
    begin
      note = note_q.pop_front();
      `CHK($sformatf("hrdata@%h", note[39:32]), note[31:0], hrdata)
    end

  // a hang ends the run as a mismatch
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    print_verdict();
  end

  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hDC17));
    loc = 7'($urandom_range(119, 8)); // clear of reserved ranges
    oth = loc ^ 7'($urandom_range(127, 1));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 20; a += 4)
      ahb(1'b0, 8'(a), 32'h0);
    ce <= 1'b0;
    repeat (2) @(posedge hclk);
    ce <= 1'b1;
    ahb(1'b1, OFS_SLV_ADDR, {25'h0, loc});
    ahb(1'b1, OFS_CONTROL, 32'h80);
    ahb(1'b0, OFS_SLV_ADDR, {25'h0, loc});
    ahb(1'b0, OFS_CONTROL, 32'h80);
    $display("test 1 done: reset and registers");
    // slave write; pins stay still long enough for the read clear
    i_rem.start_cond();
    i_rem.send_byte({loc, 1'b0}, 1'b0);
    i_rem.wait_clk(16);
    ahb(1'b0, OFS_STATUS, 32'h14);
    ahb(1'b1, OFS_IRQ_MASK, 32'h1);
    @(negedge hclk);
    `CHK("irq", 1'b1, irq)
    @(posedge hclk);
    ahb(1'b0, OFS_IRQ_ST, 32'h3);
    @(negedge hclk);
    `CHK("irq", 1'b0, irq)
    @(posedge hclk);
    ahb(1'b1, OFS_IRQ_MASK, 32'h0);
    ahb(1'b1, OFS_CONTROL, 32'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    i_rem.stop_cond();
    ahb(1'b1, OFS_CONTROL, 32'h80);
    $display("test 2 done: slave write and interrupt");
    // slave read: device drives after the ninth clock
    so_latch <= 1'b0;
    i_rem.start_cond();
    i_rem.send_byte({loc, 1'b1}, 1'b0);
    i_rem.wait_clk(8);
    @(negedge hclk);
    `CHK("sda_oe_n", 1'b0, sda_oe_n)
    @(posedge hclk);
    ahb(1'b0, OFS_STATUS, 32'h1C);
    so_latch <= 1'b1;
    i_rem.wait_clk(2);
    @(negedge hclk);
    `CHK("sda_oe_n", 1'b1, sda_oe_n)
    @(posedge hclk);
    i_rem.send_byte(8'hFF, 1'b1);
    i_rem.wait_clk(8);
    ahb(1'b0, OFS_STATUS, 32'h18);
    i_rem.stop_cond();
    ahb(1'b0, OFS_STATUS, 32'h0);
    @(negedge hclk);
    `CHK("sda_oe_n", 1'b1, sda_oe_n)
    @(posedge hclk);
    // wait release written as the ninth clock of byte two falls
    i_rem.start_cond();
    i_rem.send_byte({loc, 1'b1}, 1'b0);
    i_rem.send_byte(8'hFF, 1'b1);
    ahb(1'b1, OFS_CONTROL, 32'hA0); // data phase shares its cycle with the agreed ninth fall
    ahb(1'b0, OFS_STATUS, 32'h10);
    i_rem.stop_cond();
    ahb(1'b0, OFS_STATUS, 32'h0);
    $display("test 3 done: slave read");
    // foreign address, then release
    i_rem.start_cond();
    i_rem.send_byte({oth, 1'b0}, 1'b0);
    i_rem.wait_clk(8);
    ahb(1'b0, OFS_STATUS, 32'h04);
    ahb(1'b1, OFS_CONTROL, 32'hC0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    ahb(1'b0, OFS_CONTROL, 32'h80);
    i_rem.stop_cond();
    $display("test 4 done: mismatch and release");
    // master start, arbitration loss, master read bit
    pulse(1'b0);
    ahb(1'b0, OFS_STATUS, 32'h88);
    pulse(1'b1);
    ahb(1'b0, OFS_STATUS, 32'h40);
    ahb(1'b0, OFS_STATUS, 32'h0);
    pulse(1'b0);
    i_rem.start_cond();
    i_rem.send_byte({oth, 1'b1}, 1'b1);
    i_rem.wait_clk(8);
    ahb(1'b0, OFS_STATUS, 32'h80);
    ahb(1'b1, OFS_CONTROL, 32'hC0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    i_rem.stop_cond();
    $display("test 5 done: master flags");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
